// [hw/plmc_link_cfg.v]
/*
 * Configuration and line-interface selection of a 10/100 transceiver:
 * strap decoding, negotiation / parallel detection / forced resolution,
 * twisted-pair and fiber enables, and the management register set
 * behind a classic Wishbone slave.
 * Assumes straps and line detector inputs are synchronous to clk_i and
 * that line detectors in the analog and coding paths report events here.
 */
`timescale 1ns/100ps
`include "plmc_regs.vh"

module plmc_link_cfg (
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [31:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Strap pins
    input wire [1:0] speed_advert_strap_i,
    input wire [1:0] an_enable_strap_i,
    input wire config_strap_a_i,
    input wire config_strap_b_i,
    input wire full_duplex_pin_i,
    input wire mgmt_disable_pin_i,
    // Line detectors
    input wire lp_page_valid_i,
    input wire [15:0] lp_page_i,
    input wire nlp_detect_i,
    input wire idle_detect_i,
    input wire link_invalid_i,
    // Line interface controls
    output wire tp_enable_o,
    output wire tp_tx_oe_o,
    output wire tp_bias_o,
    output wire fx_enable_o,
    output wire fx_drive_low_o,
    output wire code_mlt3_o,
    output wire code_scramble_o,
    output wire code_manchester_o,
    output wire code_nrzi_o,
    output wire idle_fill_o,
    output wire link_pulse_en_o,
    output wire flp_tx_en_o,
    // MAC-side status and drive
    output wire mii_speed_100_o,
    output wire mii_full_duplex_o,
    output wire mii_drive_reduced_o,
    output wire link_up_o
);

    // One-hot link states
    localparam [4:0] ST_OFF = 5'h01;
    localparam [4:0] ST_NEG = 5'h02;
    localparam [4:0] ST_LINK_AN = 5'h04;
    localparam [4:0] ST_LINK_PD = 5'h08;
    localparam [4:0] ST_FORCED = 5'h10;

    // Register storage
    reg [15:0] ctrl_q;
    reg [15:0] adv_q;
    reg [15:0] lpa_q;
    reg [15:0] mirror_q;
    reg [15:0] cfg_q;
    reg [15:0] mode_q;
    reg lp_an_q;
    reg pd_used_q;

    // Link resolution state
    reg [4:0] state_q;
    reg [4:0] state_d;
    reg speed_100_q;
    reg speed_100_d;
    reg full_q;
    reg full_d;
    reg link_q;
    reg link_d;

    // Bus and strap tracking
    reg ack_q;
    reg [15:0] rdat_q;
    reg init_q;
    reg cfg_a_q;

    wire req = wb_cyc_i & wb_stb_i;
    wire [4:0] idx = wb_adr_i[6:2];
    wire in_range = (wb_adr_i[31:7] == 25'h0000000);
    // Writes land on the edge that sees ack high, where the master takes the answer
    wire wr_now = req & wb_we_i & ack_q & in_range;
    wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Strap lookups, purely combinational on the level code
    wire spd_outer = (speed_advert_strap_i == `PLMC_LVL_HIGH) |
                     (speed_advert_strap_i == `PLMC_LVL_GROUND);
    wire an_strap = (an_enable_strap_i == `PLMC_LVL_MID_HIGH) |
                    (an_enable_strap_i == `PLMC_LVL_MID_LOW);
    reg [3:0] strap_adv;

    // Advertisement bits 8..5 from speed strap, strap B and duplex pin
    always @* begin
        if (spd_outer && !config_strap_b_i) begin
            strap_adv = 4'hf;
        end else if (spd_outer) begin
            strap_adv = {1'b0, 1'b0, full_duplex_pin_i, 1'b1};
        end else if (!config_strap_b_i) begin
            strap_adv = {full_duplex_pin_i, 1'b1, 1'b0, 1'b0};
        end else begin
            strap_adv = {full_duplex_pin_i, 1'b1, full_duplex_pin_i, 1'b1};
        end
    end

    // Derived mode controls
    // Power-down overrides every other mode bit
    wire pdown = ctrl_q[`PLMC_CTRL_PDOWN];
    wire fx_sel = mode_q[`PLMC_MODE_FX];
    wire an_on = ctrl_q[`PLMC_CTRL_AN_EN] & ~fx_sel;
    wire tp_en = ~pdown & ~fx_sel & ~mode_q[`PLMC_MODE_TX_DISC];
    wire fx_en = ~pdown & fx_sel;
    wire restart_strap = an_on & config_strap_a_i & ~cfg_a_q;
    wire ctrl_wr = wr_now & (idx == `PLMC_IDX_CTRL);
    wire restart_wr = ctrl_wr & wb_sel_i[1] & wb_dat_i[`PLMC_CTRL_AN_RST];
    wire restart = restart_strap | restart_wr | ctrl_q[`PLMC_CTRL_AN_RST];

    // Highest common ability from both pages
    // An empty common set keeps negotiating rather than guessing a mode
    wire [3:0] common = adv_q[8:5] & lp_page_i[8:5];

    // Line state resolution
    // Parallel detection only counts while no pages arrive, so a
    // negotiating partner is never mistaken for a legacy one
    always @* begin
        state_d = state_q;
        speed_100_d = speed_100_q;
        full_d = full_q;
        link_d = link_q;
        case (state_q)
            ST_OFF: begin
                link_d = 1'b0;
                // Wait for the strap load, so the first choice between
                // negotiation and forced mode sees the strapped enable
                if (!pdown && !init_q) begin
                    state_d = an_on ? ST_NEG : ST_FORCED;
                end
            end
            ST_NEG: begin
                link_d = 1'b0;
                if (lp_page_valid_i && common != 4'h0) begin
                    state_d = ST_LINK_AN;
                    link_d = 1'b1;
                    speed_100_d = common[3] | common[2];
                    full_d = common[3] | (~common[2] & common[1]);
                end else if (!lp_page_valid_i && idle_detect_i) begin
                    state_d = ST_LINK_PD;
                    link_d = 1'b1;
                    speed_100_d = 1'b1;
                    full_d = 1'b0;
                end else if (!lp_page_valid_i && nlp_detect_i) begin
                    state_d = ST_LINK_PD;
                    link_d = 1'b1;
                    speed_100_d = 1'b0;
                    full_d = 1'b0;
                end
            end
            ST_LINK_AN, ST_LINK_PD: begin
                if (link_invalid_i || restart) begin
                    state_d = ST_NEG;
                    link_d = 1'b0;
                end else if (state_q == ST_LINK_PD && ctrl_wr && wb_sel_i[1]) begin
                    full_d = wb_dat_i[`PLMC_CTRL_DUPLEX];
                end
            end
            ST_FORCED: begin
                // Speed and duplex from the control bits; fiber selection forces 100 Mbps
                speed_100_d = ctrl_q[`PLMC_CTRL_SPEED] | fx_sel;
                full_d = ctrl_q[`PLMC_CTRL_DUPLEX];
                // Fiber lacks signal detect, so the attachment logic decides
                link_d = ~link_invalid_i &
                         (speed_100_d ? idle_detect_i : nlp_detect_i);
            end
            default: begin
                state_d = ST_OFF;
                link_d = 1'b0;
            end
        endcase
        // Mode changes override whatever the state decided
        if (pdown) begin
            state_d = ST_OFF;
            link_d = 1'b0;
        end else if (state_q != ST_OFF && !an_on && state_q != ST_FORCED) begin
            state_d = ST_FORCED;
            link_d = 1'b0;
        end else if (an_on && (state_q == ST_FORCED || restart)) begin
            state_d = ST_NEG;
            link_d = 1'b0;
        end
    end

    // State and resolved line parameters
    // Strap A history resets low but reloads from the pin on the first
    // edge, while negotiation is still off, so no false restart follows
    always @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= ST_OFF;
            speed_100_q <= 1'b0;
            full_q <= 1'b0;
            link_q <= 1'b0;
            cfg_a_q <= 1'b0;
        end else begin
            state_q <= state_d;
            speed_100_q <= speed_100_d;
            full_q <= full_d;
            link_q <= link_d;
            cfg_a_q <= config_strap_a_i;
        end
    end

    // Wishbone handshake; read data sampled as ack rises
    // Ack only every other cycle, so a request still held after
    // its ack is not taken twice
    always @(posedge clk_i) begin
        if (reset_i) begin
            ack_q <= 1'b0;
            rdat_q <= 16'h0000;
        end else begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q) begin
                rdat_q <= in_range ? rd_mux(idx) : 16'h0000;
            end
        end
    end

    // Read multiplexer; unmapped indices read zero
    function [15:0] rd_mux;
        input [4:0] i;
        begin
            case (i)
                `PLMC_IDX_CTRL: rd_mux = ctrl_q;
                `PLMC_IDX_STAT: begin
                    rd_mux = `PLMC_STAT_ABIL;
                    rd_mux[`PLMC_STAT_AN_DONE] = (state_q == ST_LINK_AN);
                    rd_mux[`PLMC_STAT_LINK] = link_q;
                end
                `PLMC_IDX_ID_HI: rd_mux = `PLMC_ID_HI_VAL;
                `PLMC_IDX_ID_LO: rd_mux = `PLMC_ID_LO_VAL;
                `PLMC_IDX_ADV: rd_mux = adv_q;
                `PLMC_IDX_LPA: rd_mux = lpa_q;
                `PLMC_IDX_EXP: rd_mux = {11'h000, pd_used_q, 3'h0, lp_an_q};
                `PLMC_IDX_MIRROR: rd_mux = mirror_q;
                `PLMC_IDX_CFG: rd_mux = cfg_q;
                `PLMC_IDX_RSVD: rd_mux = 16'h0000;
                `PLMC_IDX_MODE: rd_mux = mode_q;
                `PLMC_IDX_CHIP: begin
                    rd_mux = 16'h0000;
                    rd_mux[`PLMC_CHIP_LINK] = link_q;
                    rd_mux[`PLMC_CHIP_FULL] = full_q;
                    rd_mux[`PLMC_CHIP_100] = speed_100_q;
                    rd_mux[`PLMC_CHIP_AN_DONE] = (state_q == ST_LINK_AN);
                end
                default: rd_mux = 16'h0000;
            endcase
        end
    endfunction

    // Register writes, strap loading and hardware-set bits.
    // Straps load once after reset release, then only while management
    // is disabled, so software settings survive in the normal case.
    always @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_q <= 16'h0000;
            adv_q <= `PLMC_ADV_SELECTOR;
            lpa_q <= 16'h0000;
            mirror_q <= 16'h0000;
            cfg_q <= 16'h0000;
            mode_q <= 16'h0000;
            lp_an_q <= 1'b0;
            pd_used_q <= 1'b0;
            init_q <= 1'b1;
        end else begin
            init_q <= 1'b0;
            if (wr_now) begin
                case (idx)
                    `PLMC_IDX_CTRL: ctrl_q <= (ctrl_q & ~wmask) | (wb_dat_i[15:0] & wmask);
                    `PLMC_IDX_ADV: adv_q <= (adv_q & ~wmask) | (wb_dat_i[15:0] & wmask);
                    `PLMC_IDX_MIRROR: mirror_q <= (mirror_q & ~wmask) |
                                                 (wb_dat_i[15:0] & wmask);
                    `PLMC_IDX_CFG: cfg_q <= (cfg_q & ~wmask) | (wb_dat_i[15:0] & wmask);
                    `PLMC_IDX_MODE: mode_q <= (mode_q & ~wmask) | (wb_dat_i[15:0] & wmask);
                    default: begin
                        // Read-only and unmapped indices drop the write
                    end
                endcase
            end
            // Restart bit clears once negotiation has been re-entered
            if (ctrl_q[`PLMC_CTRL_AN_RST] && state_q == ST_NEG && !restart_wr) begin
                ctrl_q[`PLMC_CTRL_AN_RST] <= 1'b0;
            end
            // A strap edge sets the restart bit; the set beats a clear
            if (restart_strap) begin
                ctrl_q[`PLMC_CTRL_AN_RST] <= 1'b1;
            end
            if (init_q || mgmt_disable_pin_i) begin
                adv_q[8:5] <= strap_adv;
                mode_q[`PLMC_MODE_LT_DIS] <= config_strap_b_i;
                if (!an_on) begin
                    ctrl_q[`PLMC_CTRL_SPEED] <= config_strap_a_i;
                end
            end
            if (init_q) begin
                // Strap-only initial values
                ctrl_q[`PLMC_CTRL_AN_EN] <= an_strap;
                ctrl_q[`PLMC_CTRL_SPEED] <= an_strap ? 1'b1 : config_strap_a_i;
                mode_q[`PLMC_MODE_FX] <= ~an_strap & ~spd_outer;
            end
            // Partner page and how the link was reached
            if (state_q == ST_NEG && lp_page_valid_i) begin
                lpa_q <= lp_page_i;
                lp_an_q <= 1'b1;
            end
            if (state_q == ST_NEG && state_d == ST_LINK_PD) begin
                pd_used_q <= 1'b1;
                lp_an_q <= 1'b0;
            end else if (state_d == ST_LINK_AN) begin
                pd_used_q <= 1'b0;
            end
            // Keep the control register showing the resolved line state; a
            // software write in the same cycle wins, and a forced link keeps
            // what software or the straps put there
            if ((state_d == ST_LINK_AN || state_d == ST_LINK_PD) && !ctrl_wr) begin
                ctrl_q[`PLMC_CTRL_SPEED] <= speed_100_d;
                ctrl_q[`PLMC_CTRL_DUPLEX] <= full_d;
            end
        end
    end

    // Bus outputs
    assign wb_ack_o = ack_q;
    assign wb_dat_o = {16'h0000, rdat_q};

    // Line interface enables
    // Fiber selection wins, so the two interfaces are never on together
    assign tp_enable_o = tp_en;
    assign tp_tx_oe_o = tp_en;
    assign tp_bias_o = tp_en;
    assign fx_enable_o = fx_en;
    assign fx_drive_low_o = ~fx_en;

    // Coding selection for the transmit and receive paths
    assign code_mlt3_o = tp_en & speed_100_q;
    assign code_scramble_o = tp_en & speed_100_q & ~mode_q[`PLMC_MODE_SCR_BYP];
    assign code_manchester_o = tp_en & ~speed_100_q;
    // Forced 10 Mbps pulses even without link, so a silent partner
    // can still detect us and bring the link up
    assign link_pulse_en_o = tp_en & ~speed_100_q & (state_q == ST_FORCED | link_q);
    assign code_nrzi_o = fx_en;
    assign idle_fill_o = (tp_en & speed_100_q) | fx_en;
    assign flp_tx_en_o = tp_en & (state_q == ST_NEG);

    // MAC-side interface follows the resolved line; drive strength comes from the configuration register
    assign mii_speed_100_o = speed_100_q;
    assign mii_full_duplex_o = full_q;
    assign mii_drive_reduced_o = cfg_q[`PLMC_CFG_DRV_LOW];
    assign link_up_o = link_q;

endmodule

// [hw/plmc_regs.vh]
/*
 * Constants of the link-mode configuration block: management register
 * indices, field positions, reset values and strap level codes.
 * Assumes the includer runs on one clock and decodes word addresses.
 */
// Overview of operation
// - Outer speed strap, config strap B low: advertise all four abilities, ignore duplex pin.
// - Outer speed strap, B high: 10 Mbps only; 10 full duplex follows duplex pin.
// - Inner speed strap, B low: 100 Mbps only; 100 full duplex follows duplex pin.
// - Inner speed strap, B high: 10 and 100 half; both full bits follow pin.
// - After reset negotiate with parallel detection, sending pulse bursts to negotiating partners.
// - Partner not negotiating: link pulses pick 10 Mbps, idle symbols pick 100 Mbps.
// - Parallel detection always gives half duplex; full only by later register write.
// - With negotiation on, speed and duplex come from exchanged capability pages.
// - Forced mode sets speed and duplex directly, with no negotiation.
// - MAC-side interface speed follows the resolved line speed automatically.
// - Registers live at indices 0 to 6 and 16 to 20, sixteen bits each.
// - 100 Mbps twisted pair uses continuous scrambled MLT-3 stream with idle fill.
// - 10 Mbps uses Manchester, idle line between frames, periodic link pulses.
// - Twisted pair off in power-down, fiber mode or transmit disconnect; tri-stated, unbiased.
// - Fiber uses continuous NRZI stream, no scrambling and no MLT-3.
// - Fiber runs forced only, never negotiates, and never runs at 10 Mbps.
// - On fiber, invalid line conditions seen by attachment logic tear the link down.
// - Fiber off in power-down or when twisted pair enabled; outputs driven low.
// - Driver strength bit: zero gives full strength, one gives reduced strength.
// - Negotiation off: config strap A high selects 100 Mbps, low selects 10.
// - Negotiation on: rising edge on config strap A restarts negotiation.
// - Management disable low: straps set initial values; high: straps control continuously; the code loads negotiation enable and fiber mode at reset only.
`ifndef PLMC_REGS_VH
`define PLMC_REGS_VH

// Register indices; byte address is four times the index
`define PLMC_IDX_CTRL 5'h00
`define PLMC_IDX_STAT 5'h01
`define PLMC_IDX_ID_HI 5'h02
`define PLMC_IDX_ID_LO 5'h03
`define PLMC_IDX_ADV 5'h04
`define PLMC_IDX_LPA 5'h05
`define PLMC_IDX_EXP 5'h06
`define PLMC_IDX_MIRROR 5'h10
`define PLMC_IDX_CFG 5'h11
`define PLMC_IDX_RSVD 5'h12
`define PLMC_IDX_MODE 5'h13
`define PLMC_IDX_CHIP 5'h14

// Control register fields
`define PLMC_CTRL_SPEED 13
`define PLMC_CTRL_AN_EN 12
`define PLMC_CTRL_PDOWN 11
`define PLMC_CTRL_AN_RST 9
`define PLMC_CTRL_DUPLEX 8

// Advertisement fields
`define PLMC_ADV_10HD 5
`define PLMC_ADV_10FD 6
`define PLMC_ADV_100HD 7
`define PLMC_ADV_100FD 8
`define PLMC_ADV_SELECTOR 16'h0001

// Fixed status abilities, link and completion bit positions
`define PLMC_STAT_ABIL 16'h7809
`define PLMC_STAT_AN_DONE 5
`define PLMC_STAT_LINK 2

// Expansion fields
`define PLMC_EXP_LP_AN 0
`define PLMC_EXP_PD 4

// Configuration register: driver strength
`define PLMC_CFG_DRV_LOW 3

// Mode register fields
`define PLMC_MODE_LT_DIS 8
`define PLMC_MODE_SCR_BYP 3
`define PLMC_MODE_FX 2
`define PLMC_MODE_TX_DISC 0

// Chip status fields
`define PLMC_CHIP_LINK 13
`define PLMC_CHIP_FULL 12
`define PLMC_CHIP_100 11
`define PLMC_CHIP_AN_DONE 9

// Identity words; values are arbitrary
`define PLMC_ID_HI_VAL 16'h1234
`define PLMC_ID_LO_VAL 16'h5670

// Two-bit level codes of the four-level straps
`define PLMC_LVL_HIGH 2'h0
`define PLMC_LVL_MID_HIGH 2'h1
`define PLMC_LVL_MID_LOW 2'h2
`define PLMC_LVL_GROUND 2'h3

`endif

// [test/phy_link_mode_config_test.sv]
/* Self-checking bench of the link-mode block over Wishbone.
   Assumes the partner model drives the line detector inputs. */
`timescale 1ns/100ps
`include "plmc_regs.vh"
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module phy_link_mode_config_test;
    reg clk_i = 0, reset_i = 1, cyc = 0, stb = 0, we = 0, cfa = 1, cfb = 0, fde = 0, mdd = 0;
    reg drop = 0;
    reg [31:0] adr = 0, dat = 0;
    reg [3:0] sel = 0;
    reg [1:0] spd = 0, anst = 1, pmode = 0;
    reg [15:0] pab = 0, r, e2;
    wire [31:0] dat_o;
    wire [15:0] pg;
    wire ack, pv, nlp, idl, inv, tp_en, fx_en, s100, fdx, drv, lnk, nrzi, flp;
    int mismatches = 0, num_checks = 0, cycles = 0, i;
    logic [15:0] expq[$];
    plmc_link_cfg uut (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .speed_advert_strap_i(spd), .an_enable_strap_i(anst),
        .config_strap_a_i(cfa), .config_strap_b_i(cfb), .full_duplex_pin_i(fde),
        .mgmt_disable_pin_i(mdd), .lp_page_valid_i(pv), .lp_page_i(pg), .nlp_detect_i(nlp),
        .idle_detect_i(idl), .link_invalid_i(inv), .tp_enable_o(tp_en), .tp_tx_oe_o(),
        .tp_bias_o(), .fx_enable_o(fx_en), .fx_drive_low_o(), .code_mlt3_o(),
        .code_scramble_o(), .code_manchester_o(), .code_nrzi_o(nrzi), .idle_fill_o(),
        .link_pulse_en_o(), .flp_tx_en_o(flp), .mii_speed_100_o(s100),
        .mii_full_duplex_o(fdx), .mii_drive_reduced_o(drv), .link_up_o(lnk));
    plmc_partner lp (.clk_i(clk_i), .mode_i(pmode), .ability_i(pab), .drop_i(drop),
        .page_valid_o(pv), .page_o(pg), .nlp_o(nlp), .idle_o(idl), .invalid_o(inv));
    // Clock and hang guard
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim;
        end
    end
    // Oldest expected read is matched against each read answer
    always @(posedge clk_i) if (ack === 1'b1 && cyc && !we) begin
        e2 = expq.pop_front();
        `CHK("read data", {16'h0, e2}, dat_o)
    end
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One classic cycle; held until ack is sampled
    task wb(input [31:0] a, input w, input [15:0] d, input [15:0] x);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {16'h0, d}; sel <= 4'h3;
        if (!w) expq.push_back(x);
        // No own limit: only the bench timeout ends a missing ack
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 0; stb <= 0; we <= 0;
        @(posedge clk_i);
    endtask
    task wl(input v);
        int n;
        n = 0;
        while (lnk !== v && n < 400) begin @(posedge clk_i); n++; end
        `CHK("link", v, lnk)
    endtask
    task rst;
        reset_i <= 1;
        repeat (3) @(posedge clk_i);
        reset_i <= 0;
        repeat (2) @(posedge clk_i);
    endtask
    // Advertisement expected from straps
    function [15:0] adv(input [1:0] s, input b, input f);
        if (s == 2'h0 || s == 2'h3) adv = b ? {7'h0, 1'b0, 1'b0, f, 1'b1, 5'h1} : 16'h01e1;
        else adv = b ? {7'h0, f, 1'b1, f, 1'b1, 5'h1} : {7'h0, f, 1'b1, 2'h0, 5'h1};
    endfunction
    initial begin
        void'($urandom(32'h2400));
        rst;
        wb(32'h08, 0, 0, `PLMC_ID_HI_VAL);
        wb(32'h1c, 0, 0, 16'h0);
        wb(32'h80, 0, 0, 16'h0);
        wb(32'h04, 0, 0, `PLMC_STAT_ABIL);
        wb(32'h44, 0, 0, 16'h0);
        r = $urandom;
        wb(32'h40, 1, r, 0);
        wb(32'h40, 0, 0, r);
        wb(32'h48, 1, r, 0);
        wb(32'h48, 0, 0, 16'h0);
        wb(32'h44, 1, 16'h0008, 0);
        `CHK("drive", 1'b1, drv)
        mdd <= 1;
        for (i = 0; i < 16; i++) begin
            spd <= i[1:0]; cfb <= i[2]; fde <= i[3];
            wb(32'h10, 0, 0, adv(i[1:0], i[2], i[3]));
        end
        mdd <= 0; spd <= 0; cfb <= 0;
        rst;
        pmode <= 1; pab <= 16'h0101;
        repeat (2) @(posedge clk_i);
        `CHK("pulse bursts", 1'b1, flp)
        wl(1);
        `CHK("speed", 1'b1, s100)
        `CHK("duplex", 1'b1, fdx)
        // Rising edge on strap A while negotiating restarts it
        cfa <= 0;
        @(posedge clk_i);
        cfa <= 1;
        repeat (2) @(posedge clk_i);
        `CHK("restart", 1'b0, lnk)
        wl(1);
        for (i = 2; i < 4; i++) begin
            pmode <= i[1:0]; drop <= 1;
            wl(0);
            drop <= 0;
            wl(1);
            `CHK("detect speed", i[0], s100)
            `CHK("detect duplex", 1'b0, fdx)
        end
        wb(32'h00, 1, 16'h3100, 0);
        `CHK("late duplex", 1'b1, fdx)
        wb(32'h00, 1, 16'h0000, 0);
        pmode <= 2;
        // Leaving negotiation drops the link before forced 10 Mbps comes up
        wl(0);
        wl(1);
        `CHK("forced speed", 1'b0, s100)
        `CHK("forced duplex", 1'b0, fdx)
        mdd <= 1;
        @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        `CHK("strap speed", 1'b1, s100)
        cfa <= 0;
        repeat (3) @(posedge clk_i);
        `CHK("strap speed", 1'b0, s100)
        mdd <= 0; cfa <= 1; pmode <= 3;
        wb(32'h4c, 1, 16'h0004, 0);
        `CHK("fiber on", 1'b1, fx_en)
        `CHK("tp off", 1'b0, tp_en)
        `CHK("nrzi", 1'b1, nrzi)
        wl(1);
        `CHK("fiber speed", 1'b1, s100)
        wb(32'h4c, 1, 16'h0001, 0);
        `CHK("tp disc", 1'b0, tp_en)
        `CHK("fiber off", 1'b0, fx_en)
        wb(32'h4c, 1, 16'h0000, 0);
        `CHK("tp on", 1'b1, tp_en)
        wb(32'h00, 1, 16'h0800, 0);
        `CHK("pd tp", 1'b0, tp_en)
        `CHK("pd fiber", 1'b0, fx_en)
        end_sim;
    end
endmodule
bind plmc_link_cfg plmc_link_cfg_sva chk (.*);

// [test/plmc_link_cfg_sva.sv]
/* Checker of the link-mode block's ports.
   Assumes it is bound to plmc_link_cfg and sees only its ports. */
`timescale 1ns/100ps
module plmc_link_cfg_sva (
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [31:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Line side
    input wire tp_enable_o,
    input wire tp_tx_oe_o,
    input wire tp_bias_o,
    input wire fx_enable_o,
    input wire fx_drive_low_o,
    input wire code_mlt3_o,
    input wire code_scramble_o,
    input wire code_manchester_o,
    input wire code_nrzi_o,
    input wire idle_fill_o,
    input wire link_pulse_en_o,
    input wire flp_tx_en_o,
    input wire mii_speed_100_o,
    input wire mii_drive_reduced_o,
    input wire link_up_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // Write of the drive-strength register completing
    sequence wr_cfg_s;
        wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 32'h44 && wb_sel_i[0];
    endsequence
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    ack_answer_a: assert property (req_s |=> wb_ack_o) else $error("no ack");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    drive_write_a: assert property (wr_cfg_s |=> mii_drive_reduced_o == $past(wb_dat_i[3]))
        else $error("drive strength not stored");
    read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0)
        else $error("upper read bits set");
    iface_excl_a: assert property (!(tp_enable_o && fx_enable_o))
        else $error("both line interfaces on");
    fx_ground_a: assert property (fx_drive_low_o == !fx_enable_o)
        else $error("fiber outputs not grounded");
    tp_tristate_a: assert property (tp_tx_oe_o == tp_enable_o && tp_bias_o == tp_enable_o)
        else $error("twisted pair drive or bias wrong");
    fx_coding_a: assert property (fx_enable_o |-> code_nrzi_o && !code_scramble_o
        && !code_mlt3_o && !flp_tx_en_o) else $error("fiber coding wrong");
    tp_fast_a: assert property (link_up_o && tp_enable_o && mii_speed_100_o
        |-> code_mlt3_o && idle_fill_o) else $error("fast coding wrong");
    tp_slow_a: assert property (link_up_o && tp_enable_o && !mii_speed_100_o
        |-> code_manchester_o && link_pulse_en_o && !idle_fill_o) else $error("slow coding wrong");
endmodule

// [test/plmc_partner.sv]
/* Remote link partner model: negotiating pages, link pulses, idle symbols.
   Assumes the bench picks the mode; mode 1 negotiates, 2 pulses, 3 idles. */
`timescale 1ns/100ps
module plmc_partner (
    // Clock and control
    input wire clk_i,
    input wire [1:0] mode_i,
    input wire [15:0] ability_i,
    input wire drop_i,
    // Line detector view
    output reg page_valid_o,
    output reg [15:0] page_o,
    output wire nlp_o,
    output wire idle_o,
    output wire invalid_o
);
    reg [2:0] tick_q = 3'h0;
    initial page_valid_o = 1'b0;
    initial page_o = 16'h0;
    // Page burst every eight cycles; between bursts the page is not held
    always @(posedge clk_i) begin
        tick_q <= tick_q + 3'h1;
        page_valid_o <= mode_i == 2'h1 && tick_q == 3'h0;
        page_o <= (mode_i == 2'h1 && tick_q == 3'h0) ? ability_i : ~page_o;
    end
    // Non-negotiating partners only show pulses or idles
    assign nlp_o = mode_i == 2'h2;
    assign idle_o = mode_i == 2'h3;
    assign invalid_o = drop_i;
endmodule
